// ### hdl/bbp_params.svh
`ifndef BBP_PARAMS_SVH
`define BBP_PARAMS_SVH
// Mode field encodings
`define BBP_SHR_MODE_SYNC 3'h0
`define BBP_SHR_MODE_ASYNC 3'h5
`define BBP_SHR_MODE_BIDIR 3'h1
`define BBP_OUT_MODE_GATED 2'h0
`define BBP_OUT_MODE_STREAM 2'h1
`define BBP_OUT_MODE_ASYNC 2'h3
// Format codes
`define BBP_FMT_RSVD 3'h0
`define BBP_FMT_CELL 3'h1
`define BBP_FMT_ISO 3'h2
`define BBP_FMT_ASY 3'h3
`define BBP_FMT_IDLE 3'h4
`define BBP_FMT_CELL_FIRST 3'h5
`define BBP_FMT_ISO_LAST 3'h6
`define BBP_FMT_ASY_LAST 3'h7
// Last byte index within a quadlet (quadlet size in bytes minus one)
`define BBP_QUADLET 2'h3
// Nominal port clock in kHz and mode C ceiling in kbyte/s
`define BBP_PORT_CLK_KHZ 20250
`define BBP_ASYNC_MAX_KBPS 10000
`define BBP_ASYNC_GAP 3'h4
`endif

// ### hdl/bbp_pkg.sv
package bbp_pkg;
   typedef enum logic [2:0] {
      BBP_MODE_A = 3'h0,
      BBP_MODE_B = 3'h1,
      BBP_MODE_C = 3'h3,
      BBP_MODE_D = 3'h2,
      BBP_MODE_BAD = 3'h6
   } bbp_mode_t;
   typedef struct packed {
      logic [2:0] fmt;
      logic [7:0] data;
   } bbp_byte_t;
endpackage : bbp_pkg

// ### hdl/bbp_port.sv
// Operation
// - Four modes from two config fields
// - Mode A: shared in, separate out
// - Modes A,B: byte every port clock; writes only, each read waits for the req/ack handshake
// - Modes A,B full duplex
// - Mode A: enable qualifies writes, full flag
// - Mode A: read enable, available flag
// - Mode B: stream out ignoring enable
// - Mode C: async separate ports duplex
// - Mode C capped at 10 Mbyte/s
// - Mode C has no full flag
// - Mode C input carries cell bytes only
// - Mode D shared port half duplex
// - Mode D output enable is direction
// - Mode D byte every port clock; writes only, each read waits for the req/ack handshake
// - Separate read and write ports A-C
// - Full flag rises only at quadlet boundary
// - Format marks cell and packet bytes
// - Format code table
// - Mode D high reads, low writes
`timescale 1ns/1ps
`include "bbp_params.svh"
module bbp_port (
   // System side
   input wire logic clk,
   input wire logic nrst,
   input wire logic [2:0] shared_port_mode_field,
   input wire logic [1:0] output_port_mode_field,
   output logic mode_unsupported,
   // Transmit FIFO side
   output bbp_pkg::bbp_byte_t tx_byte,
   output logic tx_valid,
   input wire logic tx_full,
   // Receive FIFO side
   input wire bbp_pkg::bbp_byte_t rx_byte,
   input wire logic rx_valid,
   output logic rx_ready,
   // Input port clock domain; shared port and input format outputs are driven on output_port_clock
   input wire logic input_port_clock,
   input wire logic input_port_enable,
   input wire logic [7:0] shared_byte_port_in,
   output logic [7:0] shared_byte_port_out,
   output logic shared_byte_port_oe_n,
   input wire logic [2:0] input_format_in,
   output logic [2:0] input_format_out,
   output logic input_format_oe_n,
   output logic input_full_flag,
   // Output port clock domain
   input wire logic output_port_clock,
   input wire logic output_port_enable,
   output logic [7:0] output_byte_port,
   output logic [2:0] output_format_bus,
   output logic output_available_flag
);
   import bbp_pkg::*;

   // -----------------------------------------------------------
   // Mode decode
   // -----------------------------------------------------------
   // Unlisted combinations park the port: no capture, no output
   wire logic is_a = shared_port_mode_field == `BBP_SHR_MODE_SYNC
                     && output_port_mode_field == `BBP_OUT_MODE_GATED;
   wire logic is_b = shared_port_mode_field == `BBP_SHR_MODE_SYNC
                     && output_port_mode_field == `BBP_OUT_MODE_STREAM;
   wire logic is_c = shared_port_mode_field == `BBP_SHR_MODE_ASYNC
                     && output_port_mode_field == `BBP_OUT_MODE_ASYNC;
   wire logic is_d = shared_port_mode_field == `BBP_SHR_MODE_BIDIR
                     && output_port_mode_field == `BBP_OUT_MODE_GATED;
   wire bbp_mode_t mode_nxt = is_a ? BBP_MODE_A : is_b ? BBP_MODE_B :
                              is_c ? BBP_MODE_C : is_d ? BBP_MODE_D : BBP_MODE_BAD;
   bbp_mode_t mode_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) mode_r <= BBP_MODE_BAD;
      else mode_r <= mode_nxt;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) mode_unsupported <= 1'b1;
      else mode_unsupported <= (mode_nxt == BBP_MODE_BAD);
   end

   // -----------------------------------------------------------
   // Mode into both port domains, two flops each
   // -----------------------------------------------------------
   // Mode is static config; a level sync is enough
   bbp_mode_t mi_s1, mi_s2, mo_s1, mo_s2;
   always_ff @(posedge input_port_clock or negedge nrst) begin
      if (!nrst) begin
         mi_s1 <= BBP_MODE_BAD;
         mi_s2 <= BBP_MODE_BAD;
      end else begin
         mi_s1 <= mode_r;
         mi_s2 <= mi_s1;
      end
   end
   always_ff @(posedge output_port_clock or negedge nrst) begin
      if (!nrst) begin
         mo_s1 <= BBP_MODE_BAD;
         mo_s2 <= BBP_MODE_BAD;
      end else begin
         mo_s1 <= mode_r;
         mo_s2 <= mo_s1;
      end
   end

   // -----------------------------------------------------------
   // Input domain: full flag sync and capture
   // -----------------------------------------------------------
   logic full_s1, full_s2;
   always_ff @(posedge input_port_clock or negedge nrst) begin
      if (!nrst) begin
         full_s1 <= 1'b0;
         full_s2 <= 1'b0;
      end else begin
         full_s1 <= tx_full;
         full_s2 <= full_s1;
      end
   end
   // Mode D write when output enable low; in modes A,B,C any enable writes
   wire logic in_dir_write = (mi_s2 != BBP_MODE_D) || !output_port_enable;
   wire logic in_mode_ok = mi_s2 != BBP_MODE_BAD;
   // Mode C is only allowed cell formats
   wire logic fmt_cell = input_format_in == `BBP_FMT_CELL
                         || input_format_in == `BBP_FMT_CELL_FIRST;
   wire logic fmt_ok = (mi_s2 != BBP_MODE_C) || fmt_cell;
   wire logic fmt_data = input_format_in != `BBP_FMT_RSVD
                         && input_format_in != `BBP_FMT_IDLE;
   // Mode C has no refusal; busy is ignored there
   wire logic full_gate = (mi_s2 == BBP_MODE_C) ? 1'b0 : input_full_flag;
   // Mode C has no busy line, so pacing is the only guard against overrun
   logic [2:0] gap_r;
   wire logic gap_ok = (mi_s2 != BBP_MODE_C) || (gap_r == `BBP_ASYNC_GAP);
   wire logic take = input_port_enable && in_dir_write && in_mode_ok
                     && !full_gate && fmt_ok && fmt_data && gap_ok;
   // Port clocks since the last capture, saturating at the mode C gap
   always_ff @(posedge input_port_clock or negedge nrst) begin
      if (!nrst) gap_r <= `BBP_ASYNC_GAP;
      else if (take) gap_r <= 3'h1;
      else if (gap_r != `BBP_ASYNC_GAP) gap_r <= gap_r + 3'h1;
   end
   logic [1:0] qcnt_r;
   wire logic [1:0] qcnt_nxt = take ? qcnt_r + 2'h1 : qcnt_r;
   // Flag only changes when the byte count sits on a quadlet edge
   wire logic at_quad = (qcnt_nxt == 2'h0);
   wire logic busy_nxt = at_quad ? (full_s2 && mi_s2 != BBP_MODE_C) : input_full_flag;
   always_ff @(posedge input_port_clock or negedge nrst) begin
      if (!nrst) begin
         qcnt_r <= 2'h0;
         input_full_flag <= 1'b0;
      end else begin
         qcnt_r <= qcnt_nxt;
         input_full_flag <= busy_nxt;
      end
   end
   // Toggle handshake toward clk; one byte held stable per toggle
   bbp_byte_t in_hold_r;
   logic in_tog_r;
   always_ff @(posedge input_port_clock or negedge nrst) begin
      if (!nrst) begin
         in_hold_r <= '0;
         in_tog_r <= 1'b0;
      end else if (take) begin
         in_hold_r <= '{fmt: input_format_in, data: shared_byte_port_in};
         in_tog_r <= ~in_tog_r;
      end
   end
   logic it_s1, it_s2, it_s3;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         it_s1 <= 1'b0;
         it_s2 <= 1'b0;
         it_s3 <= 1'b0;
      end else begin
         it_s1 <= in_tog_r;
         it_s2 <= it_s1;
         it_s3 <= it_s2;
      end
   end
   // Hold settled for two clk cycles before clk samples it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_valid <= 1'b0;
         tx_byte <= '0;
      end else begin
         tx_valid <= it_s2 ^ it_s3;
         tx_byte <= in_hold_r;
      end
   end

   // -----------------------------------------------------------
   // Receive path: clk side handshake, output domain drive
   // -----------------------------------------------------------
   // Four-phase req/ack; rx byte held in clk domain while req up
   bbp_byte_t rx_hold_r;
   logic req_r, ack_s1, ack_s2, ack_r;
   wire logic rx_take = rx_valid && !req_r && !ack_s2;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_hold_r <= '0;
         req_r <= 1'b0;
         rx_ready <= 1'b0;
      end else begin
         if (rx_take) rx_hold_r <= rx_byte;
         req_r <= rx_take ? 1'b1 : (ack_s2 ? 1'b0 : req_r);
         rx_ready <= !req_r && !ack_s2 && !rx_valid;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= ack_r;
         ack_s2 <= ack_s1;
      end
   end
   logic rq_s1, rq_s2;
   always_ff @(posedge output_port_clock or negedge nrst) begin
      if (!nrst) begin
         rq_s1 <= 1'b0;
         rq_s2 <= 1'b0;
      end else begin
         rq_s1 <= req_r;
         rq_s2 <= rq_s1;
      end
   end
   // Pending byte in output domain = request seen, not yet acked
   wire logic pend = rq_s2 && !ack_r;
   // Mode B drains without waiting; A,C wait on enable; D on enable and read
   wire logic rd_en = (mo_s2 == BBP_MODE_B) ? 1'b1 :
                      (mo_s2 == BBP_MODE_D) ? (input_port_enable && output_port_enable) :
                      (mo_s2 == BBP_MODE_BAD) ? 1'b0 : output_port_enable;
   wire logic deliver = pend && rd_en;
   wire logic to_sep = mo_s2 != BBP_MODE_D;
   always_ff @(posedge output_port_clock or negedge nrst) begin
      if (!nrst) ack_r <= 1'b0;
      else ack_r <= deliver ? 1'b1 : (!rq_s2 ? 1'b0 : ack_r);
   end
   // Data on separate port in A,B,C; shared port in D
   always_ff @(posedge output_port_clock or negedge nrst) begin
      if (!nrst) begin
         output_byte_port <= 8'h00;
         output_format_bus <= `BBP_FMT_IDLE;
         shared_byte_port_out <= 8'h00;
         input_format_out <= `BBP_FMT_IDLE;
         output_available_flag <= 1'b0;
      end else begin
         output_byte_port <= (deliver && to_sep) ? rx_hold_r.data : output_byte_port;
         output_format_bus <= (deliver && to_sep) ? rx_hold_r.fmt : `BBP_FMT_IDLE;
         shared_byte_port_out <= (deliver && !to_sep) ? rx_hold_r.data : shared_byte_port_out;
         input_format_out <= (deliver && !to_sep) ? rx_hold_r.fmt : `BBP_FMT_IDLE;
         output_available_flag <= pend && !deliver && mo_s2 != BBP_MODE_BAD;
      end
   end
   // Drive shared port only in mode D during a read; otherwise input
   always_ff @(posedge output_port_clock or negedge nrst) begin
      if (!nrst) begin
         shared_byte_port_oe_n <= 1'b1;
         input_format_oe_n <= 1'b1;
      end else begin
         shared_byte_port_oe_n <= !(deliver && !to_sep);
         input_format_oe_n <= !(deliver && !to_sep);
      end
   end

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   chk_c_no_busy: assert property (@(posedge input_port_clock) disable iff (!nrst)
      (mi_s2 == BBP_MODE_C && $past(mi_s2) == BBP_MODE_C && !$past(input_full_flag)) |-> !input_full_flag)
      else $error("full flag raised in mode C");
   chk_busy_quad: assert property (@(posedge input_port_clock) disable iff (!nrst)
      $rose(input_full_flag) |-> qcnt_r == 2'h0)
      else $error("full flag rose off quadlet");
   chk_busy_blocks: assert property (@(posedge input_port_clock) disable iff (!nrst)
      (input_full_flag && mi_s2 != BBP_MODE_C) |-> !take)
      else $error("byte taken while full");
   chk_take_toggle: assert property (@(posedge input_port_clock) disable iff (!nrst)
      take |=> in_tog_r != $past(in_tog_r))
      else $error("captured byte not handed over");
   chk_unsup_idle: assert property (@(posedge output_port_clock) disable iff (!nrst)
      mo_s2 == BBP_MODE_BAD |=> output_format_bus == `BBP_FMT_IDLE && shared_byte_port_oe_n)
      else $error("output active in unsupported mode");
   chk_b_stream: assert property (@(posedge output_port_clock) disable iff (!nrst)
      (mo_s2 == BBP_MODE_B && pend) |-> deliver)
      else $error("mode B stalled on enable");
   chk_a_gate: assert property (@(posedge output_port_clock) disable iff (!nrst)
      (mo_s2 == BBP_MODE_A && !output_port_enable) |-> !deliver)
      else $error("mode A delivered without enable");
   chk_d_dir: assert property (@(posedge output_port_clock) disable iff (!nrst)
      (mo_s2 == BBP_MODE_D && deliver) |=> !shared_byte_port_oe_n)
      else $error("mode D read did not drive shared port");
   chk_c_fmt: assert property (@(posedge input_port_clock) disable iff (!nrst)
      (mi_s2 == BBP_MODE_C && take) |-> fmt_cell)
      else $error("non-cell byte taken in mode C");
   chk_c_spacing: assert property (@(posedge input_port_clock) disable iff (!nrst)
      (mi_s2 == BBP_MODE_C && take) |=> (!take || mi_s2 != BBP_MODE_C) [*3])
      else $error("mode C bytes taken too close together");
   cov_a_write: cover property (@(posedge input_port_clock) disable iff (!nrst) mi_s2 == BBP_MODE_A && take);
   cov_busy: cover property (@(posedge input_port_clock) disable iff (!nrst) $rose(input_full_flag));
   cov_b_out: cover property (@(posedge output_port_clock) disable iff (!nrst) mo_s2 == BBP_MODE_B && deliver);
   cov_d_read: cover property (@(posedge output_port_clock) disable iff (!nrst) mo_s2 == BBP_MODE_D && deliver);
endmodule : bbp_port

// ### sim/bbp_host.sv
`timescale 1ns/1ps
module bbp_host (
   // Port clock
   input wire logic port_clock,
   // Bench commands
   input wire logic wr_req,
   input wire bbp_pkg::bbp_byte_t wr_byte,
   input wire logic rd_req,
   input wire logic bidir,
   // Application pins
   output logic port_enable,
   output logic direction_read,
   output logic [7:0] data_out,
   output logic [2:0] format_out
);
   import bbp_pkg::*;
   // -----
   // Application side
   // -----
   // Known levels from time zero, one driver per line
   logic en_r = 1'b0;
   logic dir_r = 1'b0;
   logic [7:0] dat_r = 8'h00;
   logic [2:0] fmt_r = 3'h4;
   assign port_enable = en_r;
   assign direction_read = dir_r;
   assign data_out = dat_r;
   assign format_out = fmt_r;
   // Change after the edge; released lines toggle so stale data never looks valid
   // Enable qualifies reads only on the shared port; elsewhere it means write
   always @(posedge port_clock) begin
      en_r <= wr_req | (rd_req & bidir);
      dir_r <= rd_req;
      dat_r <= wr_req ? wr_byte.data : ~dat_r;
      fmt_r <= wr_req ? wr_byte.fmt : ~fmt_r;
   end
endmodule : bbp_host

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
   import bbp_pkg::*;
   // -----
   // Clocks, wiring, monitors
   // -----
   logic clk = 0, pclk = 0, nrst = 0, tx_full = 0, rx_valid = 0, wr_req = 0, rd_req = 0;
   logic [2:0] smode = 3'h0;
   logic [1:0] omode = 2'h0;
   bbp_byte_t rx_byte = '0, wr_byte = '0, tx_byte, last_rd, txq[$];
   logic tx_valid, rx_ready, unsup, ien, oen, ifull, avail, doe, foe;
   logic [7:0] din, dout, obyte, hd;
   logic [2:0] fin, fout, ofmt, hf;
   int error_cnt = 0, comparisons = 0, rd_cnt = 0;
   always #12.5 clk = ~clk;
   // One slow clock feeds both ports; its edges never meet a rising clk edge
   always #80 pclk = ~pclk;
   // Shared wire: device drives when its enable is low
   assign din = doe ? hd : dout;
   assign fin = foe ? hf : fout;
   bbp_port i_dut (.clk(clk), .nrst(nrst), .shared_port_mode_field(smode), .output_port_mode_field(omode),
      .mode_unsupported(unsup), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_full(tx_full), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .input_port_clock(pclk), .input_port_enable(ien),
      .shared_byte_port_in(din), .shared_byte_port_out(dout), .shared_byte_port_oe_n(doe),
      .input_format_in(fin), .input_format_out(fout), .input_format_oe_n(foe), .input_full_flag(ifull),
      .output_port_clock(pclk), .output_port_enable(oen), .output_byte_port(obyte),
      .output_format_bus(ofmt), .output_available_flag(avail));
   bbp_host i_host (.port_clock(pclk), .wr_req(wr_req), .wr_byte(wr_byte), .rd_req(rd_req), .bidir(smode == 3'h1),
      .port_enable(ien), .direction_read(oen), .data_out(hd), .format_out(hf));
   // Sample between edges so no race with the design
   always @(negedge clk) if (tx_valid === 1'b1) txq.push_back(tx_byte);
   always @(negedge pclk) begin
      if (ofmt !== 3'h4) last_rd = {ofmt, obyte};
      if (doe === 1'b0 && foe === 1'b0) last_rd = {fout, dout};
      if (ofmt !== 3'h4 || doe === 1'b0) rd_cnt++;
   end
   // -----
   // Helpers
   // -----
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // Mode needs a few port clocks to reach both domains
   task automatic set_mode(input logic [4:0] m);
      @(posedge clk);
      {smode, omode} <= m;
      repeat (8) @(posedge pclk);
      @(posedge clk);
   endtask : set_mode
   task automatic put(input logic [10:0] b);
      @(posedge clk);
      wr_byte <= b;
      wr_req <= 1'b1;
      @(posedge pclk);
      @(posedge clk);
      wr_req <= 1'b0;
   endtask : put
   task automatic tx_is(input logic [10:0] e);
      logic [10:0] g;
      repeat (12) @(posedge clk);
      g = (txq.size() > 0) ? txq.pop_front() : 11'h7FF;
      chk(g, e);
   endtask : tx_is
   // Hold valid until ready is seen, then read it back through the port
   task automatic rd(input logic [10:0] b, input logic en);
      int n0;
      @(posedge clk);
      n0 = rd_cnt;
      rx_byte <= b;
      rx_valid <= 1'b1;
      for (int i = 0; i < 200 && rx_ready !== 1'b1; i++) @(negedge clk);
      @(posedge clk);
      rx_valid <= 1'b0;
      for (int i = 0; i < 100 && avail !== 1'b1 && rd_cnt == n0; i++) @(negedge clk);
      repeat (20) @(posedge clk);
      if (en) chk(11'(avail), 11'h1);
      rd_req <= en;
      for (int i = 0; i < 200 && rd_cnt == n0; i++) @(negedge clk);
      @(posedge clk);
      rd_req <= 1'b0;
      chk(last_rd, b);
   endtask : rd
   // -----
   // Scenarios
   // -----
   task automatic t_modes;
      logic [4:0] ok [4] = '{5'h00, 5'h01, 5'h17, 5'h04};
      for (int i = 0; i < 4; i++) begin
         set_mode(ok[i]);
         chk(11'(unsup), 11'h0);
      end
      set_mode(5'h1E);
      chk(11'(unsup), 11'h1);
      put(11'h111);
      repeat (12) @(posedge clk);
      chk(11'(txq.size()), 11'h0);
      $display("modes done");
   endtask : t_modes
   task automatic t_write_a;
      logic [10:0] w [6] = '{11'h5A1, 11'h0B2, 11'h2C3, 11'h4D4, 11'h3E5, 11'h7F6};
      set_mode(5'h00);
      for (int i = 0; i < 6; i++) put(w[i]);
      foreach (w[i]) if (w[i][10:8] != 3'h0 && w[i][10:8] != 3'h4) tx_is(w[i]);
      chk(11'(txq.size()), 11'h0);
      $display("write A done");
   endtask : t_write_a
   task automatic t_full;
      put(11'h101);
      tx_full <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(11'(ifull), 11'h0);
      for (int i = 2; i < 6; i++) put(11'h100 + 11'(i));
      for (int i = 1; i < 5; i++) tx_is(11'h100 + 11'(i));
      chk(11'(txq.size()), 11'h0);
      chk(11'(ifull), 11'h1);
      tx_full <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(11'(ifull), 11'h0);
      put(11'h106);
      tx_is(11'h106);
      $display("full flag done");
   endtask : t_full
   task automatic t_read;
      rd(11'h53C, 1'b1);
      set_mode(5'h01);
      rd(11'h15A, 1'b0);
      set_mode(5'h17);
      tx_full <= 1'b1;
      txq.delete();
      put(11'h121);
      repeat (2) @(posedge pclk);
      put(11'h222);
      repeat (2) @(posedge pclk);
      put(11'h523);
      chk(11'(ifull), 11'h0);
      tx_is(11'h121);
      tx_is(11'h523);
      tx_full <= 1'b0;
      rd(11'h144, 1'b1);
      set_mode(5'h04);
      put(11'h131);
      tx_is(11'h131);
      rd(11'h777, 1'b1);
      chk(11'(txq.size()), 11'h0);
      $display("read and modes C, D done");
   endtask : t_read
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk);
      chk(11'(ofmt), 11'h4);
      chk(11'(unsup), 11'h1);
      nrst <= 1'b1;
      t_modes();
      t_write_a();
      t_full();
      t_read();
      close_out();
   end
   initial begin
      #400000;
      error_cnt++;
      close_out();
   end
endmodule : tb
